/* File: rfb_defines.vh */
// constants for the reset-cause flag and brown-out threshold block
// assumes a 250 MHz system clock and an 8-bit register port
`ifndef RFB_DEFINES_VH
`define RFB_DEFINES_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RFB_CLK_NS            4
// software reset delay, in ns
`define RFB_SRESET_NS         16000
// brown-out qualification time, in ns
`define RFB_LVR_NS            120000
// least times round up to whole cycles
`define RFB_SRESET_CYC        ((`RFB_SRESET_NS + `RFB_CLK_NS - 1) / `RFB_CLK_NS)
`define RFB_LVR_CYC           ((`RFB_LVR_NS + `RFB_CLK_NS - 1) / `RFB_CLK_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RFB_ADDR_CAUSE        8'h00
`define RFB_ADDR_THRESH       8'h01
`define RFB_ADDR_KEY          8'h02
`define RFB_ADDR_WAKE         8'h03
`define RFB_ADDR_IRQ_STAT     8'h04
`define RFB_ADDR_IRQ_MASK     8'h05

// ----------------------------------------------------------------
// cause flag bit positions
// ----------------------------------------------------------------
`define RFB_BIT_WDT_CORRUPT   0
`define RFB_BIT_THR_CORRUPT   1
`define RFB_BIT_BROWNOUT      2
`define RFB_BIT_SW_RESET      3

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define RFB_IRQ_SW            0
`define RFB_IRQ_BROWNOUT      1
`define RFB_IRQ_THR           2
`define RFB_IRQ_WAKE          3
`define RFB_IRQ_WDT           4
`define RFB_IRQ_W             5

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define RFB_THR_1V70          8'h66
`define RFB_THR_1V90          8'h55
`define RFB_THR_2V55          8'h33
`define RFB_THR_3V15          8'h99
`define RFB_THR_3V80          8'haa
`define RFB_THR_OFF           8'hf0
`define RFB_THR_RST           8'h66
`define RFB_KEY_A             8'h55
`define RFB_KEY_B             8'haa
`define RFB_KEY_RST           8'h55
`define RFB_WAKE_OFF          8'haa
`define RFB_WAKE_RST          8'haa

`endif

/* File: rfb_delay_cnt.v */
// qualifying delay counter: one registered pulse after arm holds COUNT cycles
// assumes arm comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module rfb_delay_cnt #(
	parameter CW    = 16,
	parameter COUNT = 4000
) (
	input  wire clk,
	input  wire rst_n,
	input  wire arm,
	output reg  done_q
);

	// ----------------------------------------------------------------
	// counter state
	// ----------------------------------------------------------------
	reg  [CW-1:0] cnt_q;   // cycles arm has been held
	reg           fired_q; // pulse already given for this arm period
	wire [CW-1:0] last_c;  // terminal count value
	wire          hit;     // terminal count reached while armed

	// terminal value, cut to the counter width on purpose
	localparam integer LAST_I = (COUNT > 1) ? COUNT - 1 : 0;

	assign last_c = LAST_I[CW-1:0];
	assign hit    = arm & ~fired_q & (cnt_q == last_c);

	// count while armed, restart whenever arm drops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= {CW{1'b0}};
			fired_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			done_q <= hit;
			if (!arm) begin
				// short episodes leave no trace
				cnt_q   <= {CW{1'b0}};
				fired_q <= 1'b0;
			end else if (hit) begin
				// one pulse per arm period
				fired_q <= 1'b1;
			end else if (!fired_q) begin
				cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

`default_nettype wire

/* File: rfb_reset_ctrl.v */
// reset-cause flags, brown-out threshold select and reset key checking
// assumes supply_low and wake_pin are asynchronous; other inputs on ref_clk
// sys_reset_req is taken by the system reset tree; rst_n is power-on only
//
// The register offsets and the strobed register port were left to the implementer.
`include "rfb_defines.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - software reset sets cause bit 3
// - bits 7 to 4 read zero
// - brown-out active except sleep and idle
// - qualified low supply resets, sets bit 2
// - short low-supply episodes are ignored
// - decode six threshold encodings
// - bad threshold: delayed reset, restore 0x66
// - bad threshold sets cause bit 1
// - brown-out reset keeps threshold contents
// - no-detector variant: bit 2 reads zero
// - no-detector variant still checks threshold
// - wake pin edge resets unless disabled or the fast oscillator is off
// - bad reset key: delayed reset, sets bit 3
module rfb_reset_ctrl #(
	parameter HAS_BROWNOUT = 1,
	parameter CW           = 16,
	parameter SRESET_CYC   = `RFB_SRESET_CYC,
	parameter LVR_CYC      = `RFB_LVR_CYC
) (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rdata_q,
	input  wire       supply_low,
	input  wire       wake_pin,
	input  wire       fast_osc_en,
	input  wire       low_power_mode,
	input  wire       wdt_corrupt,
	output reg  [2:0] threshold_level_q,
	output reg        brownout_en_q,
	output reg        sys_reset_req_q,
	output wire       irq
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// one of the five voltage encodings
	function thr_is_level;
		input [7:0] code;
		begin
			thr_is_level = (code == `RFB_THR_1V70) || (code == `RFB_THR_1V90) ||
				(code == `RFB_THR_2V55) || (code == `RFB_THR_3V15) ||
				(code == `RFB_THR_3V80);
		end
	endfunction

	// voltage index 0..4 for the comparator
	function [2:0] thr_index;
		input [7:0] code;
		begin
			if (code == `RFB_THR_1V70) begin
				thr_index = 3'h0;
			end else if (code == `RFB_THR_1V90) begin
				thr_index = 3'h1;
			end else if (code == `RFB_THR_2V55) begin
				thr_index = 3'h2;
			end else if (code == `RFB_THR_3V15) begin
				thr_index = 3'h3;
			end else begin
				thr_index = 3'h4;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------------------------------
	reg        rst_s1_q;    // reset release stage 1
	reg        rst_s2_q;    // reset release stage 2
	wire       rst_sync_n;  // released power-on reset
	reg  [1:0] low_sync_q;  // supply comparator synchroniser
	reg  [1:0] wake_sync_q; // wake pin synchroniser
	reg        wake_prev_q; // last synchronised wake level

	// release reset through two flops
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	assign rst_sync_n = rst_s2_q;

	// two-flop synchronisers, first stage read only by the second
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			low_sync_q  <= 2'h0;
			wake_sync_q <= 2'h0;
			wake_prev_q <= 1'b0;
		end else begin
			low_sync_q  <= {low_sync_q[0], supply_low};
			wake_sync_q <= {wake_sync_q[0], wake_pin};
			wake_prev_q <= wake_sync_q[1];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg  [3:0]          cause_q;  // sticky reset cause flags
	reg  [3:0]          cause_d;
	reg  [7:0]          thr_q;    // brownout_threshold_select
	reg  [7:0]          key_q;    // reset_key_register
	reg  [7:0]          wake_q;   // wake_detect_enable_field
	reg  [`RFB_IRQ_W-1:0] istat_q;  // interrupt status, clear on read
	reg  [`RFB_IRQ_W-1:0] istat_d;
	reg  [`RFB_IRQ_W-1:0] imask_q;  // interrupt mask
	reg  [7:0]          rdata_d;

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	wire thr_off;     // threshold selects brown-out off
	wire thr_bad;     // threshold holds an undefined code
	wire key_bad;     // reset key holds an undefined code
	wire lvr_arm;     // low supply seen while brown-out active
	wire sw_done;     // key delay expired
	wire thr_done;    // threshold delay expired
	wire lvr_done;    // low supply qualified
	wire wake_evt;    // wake pin reset event
	wire wr_cause;
	wire wr_thr;
	wire wr_key;
	wire wr_wake;
	wire wr_imask;
	wire rd_istat;

	assign wr_cause = wr_en && (addr == `RFB_ADDR_CAUSE);
	assign wr_thr   = wr_en && (addr == `RFB_ADDR_THRESH);
	assign wr_key   = wr_en && (addr == `RFB_ADDR_KEY);
	assign wr_wake  = wr_en && (addr == `RFB_ADDR_WAKE);
	assign wr_imask = wr_en && (addr == `RFB_ADDR_IRQ_MASK);
	assign rd_istat = rd_en && (addr == `RFB_ADDR_IRQ_STAT);

	// checked on the stored value, so the cycle after the write
	assign thr_off = (thr_q == `RFB_THR_OFF);
	assign thr_bad = !thr_is_level(thr_q) && !thr_off;
	assign key_bad = (key_q != `RFB_KEY_A) && (key_q != `RFB_KEY_B);

	// brown-out only watches while enabled and awake
	assign lvr_arm = (HAS_BROWNOUT != 0) && brownout_en_q && low_sync_q[1];

	// rising wake edge, unless disabled or the fast oscillator is off
	assign wake_evt = wake_sync_q[1] && !wake_prev_q &&
		(wake_q != `RFB_WAKE_OFF) && fast_osc_en;

	// software reset delay for the key register
	rfb_delay_cnt #(
		.CW    (CW),
		.COUNT (SRESET_CYC)
	) u_key_dly (
		.clk    (ref_clk),
		.rst_n  (rst_sync_n),
		.arm    (key_bad),
		.done_q (sw_done)
	);

	// software reset delay for the threshold register
	rfb_delay_cnt #(
		.CW    (CW),
		.COUNT (SRESET_CYC)
	) u_thr_dly (
		.clk    (ref_clk),
		.rst_n  (rst_sync_n),
		.arm    (thr_bad),
		.done_q (thr_done)
	);

	// brown-out qualification, drops on any recovery
	rfb_delay_cnt #(
		.CW    (CW),
		.COUNT (LVR_CYC)
	) u_lvr_dly (
		.clk    (ref_clk),
		.rst_n  (rst_sync_n),
		.arm    (lvr_arm),
		.done_q (lvr_done)
	);

	// ----------------------------------------------------------------
	// cause flags
	// ----------------------------------------------------------------

	// zero write clears, one keeps, hardware set wins
	always @* begin
		cause_d = cause_q;
		if (wr_cause) begin
			cause_d = cause_q & wdata[3:0];
		end
		if (sw_done) begin
			cause_d[`RFB_BIT_SW_RESET] = 1'b1;
		end
		if (lvr_done) begin
			cause_d[`RFB_BIT_BROWNOUT] = 1'b1;
		end
		if (thr_done) begin
			cause_d[`RFB_BIT_THR_CORRUPT] = 1'b1;
		end
		if (wdt_corrupt) begin
			cause_d[`RFB_BIT_WDT_CORRUPT] = 1'b1;
		end
		if (HAS_BROWNOUT == 0) begin
			cause_d[`RFB_BIT_BROWNOUT] = 1'b0;
		end
	end

	// of the resets, only power-on clears the flags
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cause_q <= 4'h0;
		end else begin
			cause_q <= cause_d;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------

	// threshold, key and wake enable registers
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			thr_q  <= `RFB_THR_RST;
			key_q  <= `RFB_KEY_RST;
			wake_q <= `RFB_WAKE_RST;
		end else begin
			// bad code restores the power-on value
			if (thr_done) begin
				thr_q <= `RFB_THR_RST;
			end else if (wr_thr) begin
				thr_q <= wdata;
			end
			// any reset this block requests restores the key
			if (sw_done || thr_done || lvr_done || wake_evt) begin
				key_q <= `RFB_KEY_RST;
			end else if (wr_key) begin
				key_q <= wdata;
			end
			if (wr_wake) begin
				wake_q <= wdata;
			end
		end
	end

	// comparator controls and system reset request
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			threshold_level_q <= 3'h0;
			brownout_en_q     <= 1'b0;
			sys_reset_req_q   <= 1'b0;
		end else begin
			threshold_level_q <= thr_index(thr_q);
			brownout_en_q     <= (HAS_BROWNOUT != 0) && thr_is_level(thr_q) &&
				!low_power_mode;
			sys_reset_req_q   <= sw_done || thr_done || lvr_done || wake_evt;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------

	// sticky events, read clears, set wins over the clear
	always @* begin
		istat_d = rd_istat ? {`RFB_IRQ_W{1'b0}} : istat_q;
		if (sw_done) begin
			istat_d[`RFB_IRQ_SW] = 1'b1;
		end
		if (lvr_done) begin
			istat_d[`RFB_IRQ_BROWNOUT] = 1'b1;
		end
		if (thr_done) begin
			istat_d[`RFB_IRQ_THR] = 1'b1;
		end
		if (wake_evt) begin
			istat_d[`RFB_IRQ_WAKE] = 1'b1;
		end
		if (wdt_corrupt) begin
			istat_d[`RFB_IRQ_WDT] = 1'b1;
		end
	end

	// status and mask storage
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			istat_q <= {`RFB_IRQ_W{1'b0}};
			imask_q <= {`RFB_IRQ_W{1'b0}};
		end else begin
			istat_q <= istat_d;
			if (wr_imask) begin
				imask_q <= wdata[`RFB_IRQ_W-1:0];
			end
		end
	end

	// level interrupt while any enabled bit is set
	assign irq = |(istat_q & imask_q);

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------

	// address decode, unmapped reads give zero
	always @* begin
		rdata_d = 8'h00;
		if (addr == `RFB_ADDR_CAUSE) begin
			rdata_d = {4'h0, cause_q};
		end else if (addr == `RFB_ADDR_THRESH) begin
			rdata_d = thr_q;
		end else if (addr == `RFB_ADDR_KEY) begin
			rdata_d = key_q;
		end else if (addr == `RFB_ADDR_WAKE) begin
			rdata_d = wake_q;
		end else if (addr == `RFB_ADDR_IRQ_STAT) begin
			rdata_d = {3'h0, istat_q};
		end else if (addr == `RFB_ADDR_IRQ_MASK) begin
			rdata_d = {3'h0, imask_q};
		end
	end

	// data valid only the cycle after the read strobe
	always @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 8'h00;
		end
	end

endmodule

`default_nettype wire

/* File: rfb_reset_ctrl_bench.sv */
// bench for the reset-cause and brown-out block, both variants
// assumes short delays: software reset 4, qualify 8 cycles
`include "rfb_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rfb_reset_ctrl_bench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        ref_clk, rst_n, wr_en, rd_en, fast_osc_en, low_power_mode, wdt_corrupt;
	logic [7:0]  addr, wdata, v, n_pulse, exp_pulse, n_nb;
	wire  [7:0]  rdata_q, rdata_nb;
	wire  [2:0]  threshold_level_q, lvl_nb;
	wire         brownout_en_q, bo_en_nb, sys_reset_req_q, req_nb, irq, irq_nb;
	wire         supply_low, wake_pin;
	int          n_fail, cmp_count;
	logic [11:0] rows [6] = '{12'h661, 12'h553, 12'h335, 12'h997, 12'haa9, 12'hf08};
	localparam int SR_CYC = 4; // short software reset delay
	localparam int LV_CYC = 8; // short qualify time

	rfb_reset_ctrl #(.SRESET_CYC(SR_CYC), .LVR_CYC(LV_CYC)) i_rfb_reset_ctrl (.ref_clk(ref_clk),
		.rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata_q(rdata_q), .supply_low(supply_low), .wake_pin(wake_pin),
		.fast_osc_en(fast_osc_en), .low_power_mode(low_power_mode), .wdt_corrupt(wdt_corrupt),
		.threshold_level_q(threshold_level_q), .brownout_en_q(brownout_en_q),
		.sys_reset_req_q(sys_reset_req_q), .irq(irq));
	// detector-less variant on the same bus
	rfb_reset_ctrl #(.HAS_BROWNOUT(0), .SRESET_CYC(SR_CYC), .LVR_CYC(LV_CYC))
		i_rfb_reset_ctrl_nb (
		.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata_q(rdata_nb), .supply_low(supply_low), .wake_pin(wake_pin),
		.fast_osc_en(fast_osc_en), .low_power_mode(low_power_mode), .wdt_corrupt(wdt_corrupt),
		.threshold_level_q(lvl_nb), .brownout_en_q(bo_en_nb),
		.sys_reset_req_q(req_nb), .irq(irq_nb));
	rfb_supply_model i_rfb_supply_model (.ref_clk(ref_clk), .supply_low(supply_low),
		.wake_pin(wake_pin));

	always #2 ref_clk = ~ref_clk;
	// count reset request pulses
	always @(posedge ref_clk) begin
		if (sys_reset_req_q === 1'b1)
			n_pulse <= n_pulse + 8'h01;
		if (req_nb === 1'b1)
			n_nb <= n_nb + 8'h01;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// read, data stands in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		v = rdata_q;
		chk(nm, v, e);
	endtask
	task automatic pulses(input logic [7:0] add);
		exp_pulse = exp_pulse + add;
		chk("pulses", n_pulse, exp_pulse);
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{ref_clk, rst_n, wr_en, rd_en, low_power_mode, wdt_corrupt} = 6'h00;
		{addr, wdata, n_pulse, exp_pulse, n_nb} = 40'h0;
		fast_osc_en = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		tick(3);
		rc(`RFB_ADDR_CAUSE, 8'h00, "cause");
		rc(`RFB_ADDR_THRESH, 8'h66, "thresh");
		rc(`RFB_ADDR_KEY, 8'h55, "key");
		rc(8'h07, 8'h00, "unmapped");
		// every defined threshold code
		for (int i = 0; i < 6; i++) begin
			wr(`RFB_ADDR_THRESH, rows[i][11:4]);
			tick(3);
			chk("level", {5'h0, threshold_level_q}, {5'h0, rows[i][3:1]});
			chk("nb level", {5'h0, lvl_nb}, {5'h0, rows[i][3:1]});
			chk("bo en", {7'h0, brownout_en_q}, {7'h0, rows[i][0]});
			chk("nb en", {7'h0, bo_en_nb}, 8'h00);
			rc(`RFB_ADDR_THRESH, rows[i][11:4], "thresh");
		end
		wr(`RFB_ADDR_THRESH, 8'h99);
		low_power_mode <= 1'b1;
		tick(3);
		chk("sleep en", {7'h0, brownout_en_q}, 8'h00);
		@(posedge ref_clk) low_power_mode <= 1'b0;
		tick(3);
		chk("wake en", {7'h0, brownout_en_q}, 8'h01);
		// short then long low supply
		i_rfb_supply_model.brown(4);
		tick(20);
		pulses(8'h00);
		i_rfb_supply_model.brown(20);
		tick(20);
		pulses(8'h01);
		chk("nb pulses", n_nb, 8'h00);
		rc(`RFB_ADDR_CAUSE, 8'h04, "cause");
		chk("nb cause", rdata_nb, 8'h00);
		rc(`RFB_ADDR_THRESH, 8'h99, "thresh");
		wr(`RFB_ADDR_CAUSE, 8'hff);
		rc(`RFB_ADDR_CAUSE, 8'h04, "cause");
		wr(`RFB_ADDR_CAUSE, 8'h00);
		rc(`RFB_ADDR_CAUSE, 8'h00, "cause");
		// undefined threshold code
		wr(`RFB_ADDR_THRESH, 8'h12);
		tick(20);
		pulses(8'h01);
		chk("nb pulses", n_nb, 8'h01);
		rc(`RFB_ADDR_THRESH, 8'h66, "thresh");
		chk("nb thresh", rdata_nb, 8'h66);
		rc(`RFB_ADDR_CAUSE, 8'h02, "cause");
		chk("nb cause", rdata_nb, 8'h02);
		wr(`RFB_ADDR_CAUSE, 8'h00);
		rc(`RFB_ADDR_IRQ_STAT, 8'h06, "stat");
		chk("nb stat", rdata_nb, 8'h04);
		// bad key with masked then unmasked interrupt
		wr(`RFB_ADDR_KEY, 8'h00);
		tick(20);
		pulses(8'h01);
		chk("irq masked", {7'h0, irq}, 8'h00);
		rc(`RFB_ADDR_KEY, 8'h55, "key");
		rc(`RFB_ADDR_CAUSE, 8'h08, "cause");
		wr(`RFB_ADDR_IRQ_MASK, 8'h01);
		tick(1);
		chk("irq", {7'h0, irq}, 8'h01);
		chk("nb irq", {7'h0, irq_nb}, 8'h01);
		rc(`RFB_ADDR_IRQ_STAT, 8'h01, "stat");
		tick(1);
		chk("irq clr", {7'h0, irq}, 8'h00);
		chk("nb irq clr", {7'h0, irq_nb}, 8'h00);
		@(posedge ref_clk) wdt_corrupt <= 1'b1;
		@(posedge ref_clk) wdt_corrupt <= 1'b0;
		rc(`RFB_ADDR_CAUSE, 8'h09, "cause");
		// wake pin: disabled, enabled, oscillator off
		i_rfb_supply_model.wake_edge;
		tick(10);
		pulses(8'h00);
		wr(`RFB_ADDR_WAKE, 8'h00);
		i_rfb_supply_model.wake_edge;
		tick(10);
		pulses(8'h01);
		@(posedge ref_clk) fast_osc_en <= 1'b0;
		i_rfb_supply_model.wake_edge;
		tick(10);
		pulses(8'h00);
		// power-on reset in mid-run clears flags and wake enable
		@(posedge ref_clk) rst_n <= 1'b0;
		@(posedge ref_clk) rst_n <= 1'b1;
		tick(3);
		rc(`RFB_ADDR_CAUSE, 8'h00, "cause");
		chk("nb cause", rdata_nb, 8'h00);
		rc(`RFB_ADDR_WAKE, 8'haa, "wake");
		finish_test;
	end

	// watchdog, about thirty-five times the expected run
	initial begin
		#40000;
		n_fail++;
		finish_test;
	end
endmodule

bind rfb_reset_ctrl rfb_reset_ctrl_props #(.SRESET_CYC(SRESET_CYC), .LVR_CYC(LVR_CYC))
	i_rfb_reset_ctrl_props (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .supply_low(supply_low),
	.low_power_mode(low_power_mode), .threshold_level_q(threshold_level_q),
	.brownout_en_q(brownout_en_q), .sys_reset_req_q(sys_reset_req_q));

`default_nettype wire

/* File: rfb_reset_ctrl_props.sv */
// checker for the reset-cause and brown-out block
// assumes a bind onto rfb_reset_ctrl with small delay parameters
`include "rfb_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module rfb_reset_ctrl_props #(
	parameter int SRESET_CYC = 4,
	parameter int LVR_CYC    = 8
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata_q,
	input wire logic       supply_low,
	input wire logic       low_power_mode,
	input wire logic [2:0] threshold_level_q,
	input wire logic       brownout_en_q,
	input wire logic       sys_reset_req_q
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	localparam int D_LO = SRESET_CYC + 2; // earliest delayed request
	localparam int D_HI = SRESET_CYC + 3; // latest delayed request
	int  lo_cnt;                          // armed low-supply run length
	wire thr_wr = wr_en && addr == `RFB_ADDR_THRESH;
	wire key_wr = wr_en && addr == `RFB_ADDR_KEY;
	wire thr_bad = thr_wr && wdata != 8'h66 && wdata != 8'h55 && wdata != 8'h33
		&& wdata != 8'h99 && wdata != 8'haa && wdata != 8'hf0;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// saturating count, equals the qualify time once per episode
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			lo_cnt <= 0;
		else if (!(supply_low && brownout_en_q))
			lo_cnt <= 0;
		else if (lo_cnt <= LVR_CYC)
			lo_cnt <= lo_cnt + 1;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	rdata_idle_a: assert property (!$past(rd_en) |-> rdata_q == 8'h00)
		else $error("read data not zero outside read");
	upper_zero_a: assert property ($past(rd_en) && $past(addr) == `RFB_ADDR_CAUSE
		|-> rdata_q[7:4] == 4'h0) else $error("cause upper bits not zero");
	bo_sleep_a: assert property ($past(low_power_mode) |-> !brownout_en_q)
		else $error("brown-out enabled in low power");
	thr_level_a: assert property (thr_wr && wdata == 8'h33 |-> ##2 threshold_level_q == 3'd2)
		else $error("threshold level wrong");
	thr_off_a: assert property (thr_wr && wdata == 8'hf0 |-> ##2 !brownout_en_q)
		else $error("brown-out not disabled");
	thr_bad_a: assert property (thr_bad |-> ##[D_LO:D_HI] sys_reset_req_q)
		else $error("bad threshold gave no delayed reset");
	key_bad_a: assert property (key_wr && wdata != 8'h55 && wdata != 8'haa
		|-> ##[D_LO:D_HI] sys_reset_req_q) else $error("bad key gave no delayed reset");
	bo_fire_a: assert property (lo_cnt == LVR_CYC |-> ##[1:8] sys_reset_req_q)
		else $error("qualified low supply gave no reset");
	req_pulse_a: assert property (sys_reset_req_q |=> !sys_reset_req_q)
		else $error("reset request longer than one cycle");
endmodule

`default_nettype wire

/* File: rfb_supply_model.sv */
// supply comparator and wake pin model
// assumes calls from the bench, levels change after rising edges
`timescale 1ns/1ps
`default_nettype none

module rfb_supply_model (
	input  wire logic ref_clk,
	output logic      supply_low,
	output logic      wake_pin
);
	// ----------------------------------------------------------------
	// levels and episodes
	// ----------------------------------------------------------------
	initial begin
		supply_low = 1'b0;
		wake_pin = 1'b0;
	end

	// low-supply episode of n cycles, short or long
	task automatic brown(input int n);
		@(posedge ref_clk);
		supply_low <= 1'b1;
		repeat (n) @(posedge ref_clk);
		supply_low <= 1'b0;
	endtask

	// one clean rising edge, long enough for the synchroniser
	task automatic wake_edge;
		@(posedge ref_clk);
		wake_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wake_pin <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

`default_nettype wire
